// file: core/fes_host.sv
// Purpose: host sequencer driving flash pins for status polling,
//          reset and protect pulse duties, commanded over AXI4-Lite
// Assumes: software issues command byte sequences through write commands
// Notes:   one command at a time; ctrl writes while busy are dropped
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module fes_host
   import fes_pkg::*;
(
   input  wire logic              aclk,          // 125 MHz clock
   input  wire logic              aresetn,       // sync reset, low active
   input  wire logic [7:0]        s_awaddr,      // write address
   input  wire logic              s_awvalid,     // write address valid
   output      logic              s_awready,     // write address ready
   input  wire logic [31:0]       s_wdata,       // write data
   input  wire logic [3:0]        s_wstrb,       // write strobes
   input  wire logic              s_wvalid,      // write data valid
   output      logic              s_wready,      // write data ready
   output      logic [1:0]        s_bresp,       // write response
   output      logic              s_bvalid,      // write response valid
   input  wire logic              s_bready,      // write response ready
   input  wire logic [7:0]        s_araddr,      // read address
   input  wire logic              s_arvalid,     // read address valid
   output      logic              s_arready,     // read address ready
   output      logic [31:0]       s_rdata,       // read data
   output      logic [1:0]        s_rresp,       // read response
   output      logic              s_rvalid,      // read data valid
   input  wire logic              s_rready,      // read data ready
   output      fes_pkg::fes_pins_t flash_o,      // flash pin drive
   input  wire logic [7:0]        flash_dq_i,    // flash data pins in
   output      logic              irq            // level interrupt
);
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ACC   = 3'b001,
      ST_GAP   = 3'b010,
      ST_RSTLO = 3'b011,
      ST_RSTHI = 3'b100,
      ST_ELEV  = 3'b101,
      ST_PULSE = 3'b110
   } fes_st_t;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a[7:2] == ofs[7:2]);
   endfunction : hit

   fes_st_t     st_reg;
   fes_pins_t   pins_reg;
   logic [2:0]  cmd_reg;
   logic        tog_reg;
   logic        busy_reg;
   logic        first_reg;
   logic [7:0]  prev_reg;
   logic [7:0]  want_reg;
   logic [7:0]  rd_reg;
   logic [18:0] addr_reg;
   logic [7:0]  wdata_reg;
   logic [31:0] cnt_reg;
   logic [31:0] tmo_cnt_reg;
   logic [31:0] tmo_reg;
   logic [31:0] pulse_reg;
   logic [1:0]  irq_st_reg;
   logic [1:0]  mask_reg;
   logic        temp_reg;
   logic [7:0]  dq_s1_reg;
   logic [7:0]  dq_s2_reg;
   logic        aw_reg;
   logic        w_reg;
   logic [7:0]  awa_reg;
   logic [31:0] wd_reg;
   logic        done_ev;
   logic        tmo_ev;
   logic        start;
   logic        wr_go;

   // ------------------------------------------------------------
   // pin input synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      dq_s1_reg <= flash_dq_i;
      dq_s2_reg <= dq_s1_reg;
   end

   // ------------------------------------------------------------
   // axi write channel
   // ------------------------------------------------------------
   assign wr_go = aw_reg && w_reg && !s_bvalid;
   assign start = wr_go && hit(awa_reg, OFS_CTRL) && !busy_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_reg    <= 1'b0;
         w_reg     <= 1'b0;
         awa_reg   <= 8'h00;
         wd_reg    <= 32'h0000_0000;
         s_awready <= 1'b0;
         s_wready  <= 1'b0;
         s_bvalid  <= 1'b0;
         s_bresp   <= 2'b00;
      end else begin
         s_awready <= !aw_reg && !s_awready && !s_bvalid;
         s_wready  <= !w_reg && !s_wready && !s_bvalid;
         if (s_awvalid && s_awready) begin
            aw_reg  <= 1'b1;
            awa_reg <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_reg  <= 1'b1;
            wd_reg <= s_wdata;
         end
         if (wr_go) begin
            aw_reg   <= 1'b0;
            w_reg    <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp  <= (awa_reg > OFS_RDATA) ? 2'b10 : 2'b00;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr_reg  <= 19'h0_0000;
         wdata_reg <= 8'h00;
         tmo_reg   <= TMO_RESET;
         pulse_reg <= PULSE_RESET;
         mask_reg  <= 2'b00;
      end else if (wr_go && s_wstrb != 4'h0) begin
         if (hit(awa_reg, OFS_ADDR))  addr_reg  <= wd_reg[18:0];
         if (hit(awa_reg, OFS_WDATA)) wdata_reg <= wd_reg[7:0];
         if (hit(awa_reg, OFS_TMO))   tmo_reg   <= wd_reg;
         if (hit(awa_reg, OFS_PULSE)) pulse_reg <= (wd_reg < PULSE_MIN_CYC) ?
                                                  32'(PULSE_MIN_CYC) : wd_reg;
         if (hit(awa_reg, OFS_MASK))  mask_reg  <= wd_reg[1:0];
      end
   end

   // set wins over write-one-to-clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_st_reg <= 2'b00;
      end else begin
         irq_st_reg <= (irq_st_reg & ~((wr_go && hit(awa_reg, OFS_IRQ)) ? wd_reg[1:0] : 2'b00))
                       | {tmo_ev, done_ev};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) irq <= 1'b0;
      else          irq <= |(irq_st_reg & mask_reg);
   end

   // ------------------------------------------------------------
   // axi read channel
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b0;
         s_rdata   <= 32'h0000_0000;
         s_rresp   <= 2'b00;
      end else begin
         s_arready <= !s_arready && !s_rvalid;
         if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rresp  <= 2'b00;
            case (s_araddr[7:2])
               OFS_CTRL[7:2]:   s_rdata <= {28'h0, tog_reg, cmd_reg};
               OFS_ADDR[7:2]:   s_rdata <= {13'h0, addr_reg};
               OFS_WDATA[7:2]:  s_rdata <= {24'h0, wdata_reg};
               OFS_STATUS[7:2]: s_rdata <= {29'h0, temp_reg, irq_st_reg[1], busy_reg};
               OFS_IRQ[7:2]:    s_rdata <= {30'h0, irq_st_reg};
               OFS_MASK[7:2]:   s_rdata <= {30'h0, mask_reg};
               OFS_TMO[7:2]:    s_rdata <= tmo_reg;
               OFS_PULSE[7:2]:  s_rdata <= pulse_reg;
               OFS_RDATA[7:2]:  s_rdata <= {24'h0, rd_reg};
               default: begin
                  s_rdata <= 32'h0000_0000;
                  s_rresp <= 2'b10;
               end
            endcase
         end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // flash pin sequencer
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg      <= ST_IDLE;
         pins_reg    <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1,
                          elevated_id_voltage: 1'b0, addr: 19'h0_0000,
                          dq_out: 8'h00, dq_oe_n: 1'b1};
         cmd_reg     <= 3'b000;
         tog_reg     <= 1'b0;
         busy_reg    <= 1'b0;
         first_reg   <= 1'b0;
         prev_reg    <= 8'h00;
         want_reg    <= 8'h00;
         rd_reg      <= 8'h00;
         cnt_reg     <= 32'h0000_0000;
         tmo_cnt_reg <= 32'h0000_0000;
         temp_reg    <= 1'b0;
         done_ev     <= 1'b0;
         tmo_ev      <= 1'b0;
      end else begin
         done_ev <= 1'b0;
         tmo_ev  <= 1'b0;
         case (st_reg)
            ST_IDLE: begin
               if (start) begin
                  cmd_reg     <= wd_reg[2:0];
                  tog_reg     <= wd_reg[CTRL_TOG_BIT];
                  busy_reg    <= 1'b1;
                  first_reg   <= 1'b1;
                  want_reg    <= wdata_reg;
                  tmo_cnt_reg <= 32'h0000_0000;
                  cnt_reg     <= 32'h0000_0000;
                  // poll reads stay on the target address, toggle may too
                  pins_reg.addr <= addr_reg;
                  case (wd_reg[2:0])
                     FES_CMD_WRITE: begin
                        pins_reg.ce_n    <= 1'b0;
                        pins_reg.we_n    <= 1'b0;
                        pins_reg.dq_out  <= wdata_reg;
                        pins_reg.dq_oe_n <= 1'b0;
                        st_reg           <= ST_ACC;
                     end
                     FES_CMD_READ, FES_CMD_POLL: begin
                        pins_reg.ce_n <= 1'b0;
                        pins_reg.oe_n <= 1'b0;
                        st_reg        <= ST_ACC;
                     end
                     FES_CMD_RESET: begin
                        pins_reg.reset_n <= 1'b0;
                        st_reg           <= ST_RSTLO;
                     end
                     FES_CMD_PROT, FES_CMD_UNPROT: begin
                        pins_reg.ce_n <= 1'b0;
                        pins_reg.we_n <= 1'b0;
                        st_reg        <= ST_PULSE;
                     end
                     FES_CMD_TEMP: begin
                        pins_reg.elevated_id_voltage <= !temp_reg;
                        temp_reg                     <= !temp_reg;
                        st_reg                       <= ST_ELEV;
                     end
                     default: begin
                        busy_reg <= 1'b0;
                        done_ev  <= 1'b1;
                     end
                  endcase
               end
            end
            ST_ACC: begin
               cnt_reg <= cnt_reg + 32'h1;
               if (cnt_reg >= 32'(ACCESS_CYC - 1)) begin
                  pins_reg.ce_n    <= 1'b1;
                  pins_reg.oe_n    <= 1'b1;
                  pins_reg.we_n    <= 1'b1;
                  pins_reg.dq_oe_n <= 1'b1;
                  cnt_reg          <= 32'h0000_0000;
                  rd_reg           <= dq_s2_reg;
                  st_reg           <= ST_GAP;
               end
            end
            ST_GAP: begin
               cnt_reg     <= cnt_reg + 32'h1;
               tmo_cnt_reg <= tmo_cnt_reg + 32'h1;
               if (cnt_reg >= 32'(ACCESS_CYC - 1)) begin
                  cnt_reg   <= 32'h0000_0000;
                  first_reg <= 1'b0;
                  prev_reg  <= rd_reg;
                  // device verifies internally; host only watches status
                  if (cmd_reg != FES_CMD_POLL ||
                      (!tog_reg && rd_reg[DATA_POLL_BIT] == want_reg[DATA_POLL_BIT]) ||
                      (tog_reg && !first_reg &&
                       rd_reg[TOGGLE_STATUS_BIT] == prev_reg[TOGGLE_STATUS_BIT])) begin
                     busy_reg <= 1'b0;
                     done_ev  <= 1'b1;
                     st_reg   <= ST_IDLE;
                  end else if (tmo_cnt_reg >= tmo_reg) begin
                     busy_reg <= 1'b0;
                     tmo_ev   <= 1'b1;
                     st_reg   <= ST_IDLE;
                  end else begin
                     pins_reg.ce_n <= 1'b0;
                     pins_reg.oe_n <= 1'b0;
                     st_reg        <= ST_ACC;
                  end
               end
            end
            ST_RSTLO: begin
               cnt_reg <= cnt_reg + 32'h1;
               if (cnt_reg >= 32'(RST_LOW_CYC - 1)) begin
                  pins_reg.reset_n <= 1'b1;
                  cnt_reg          <= 32'h0000_0000;
                  st_reg           <= ST_RSTHI;
               end
            end
            ST_RSTHI: begin
               cnt_reg <= cnt_reg + 32'h1;
               // wait out worst ready time plus release recovery
               if (cnt_reg >= 32'(READY_OP_CYC + RST_HIGH_CYC - 1)) begin
                  busy_reg <= 1'b0;
                  done_ev  <= 1'b1;
                  st_reg   <= ST_IDLE;
               end
            end
            ST_ELEV: begin
               cnt_reg <= cnt_reg + 32'h1;
               if (cnt_reg >= 32'(ELEV_CYC - 1)) begin
                  busy_reg <= 1'b0;
                  done_ev  <= 1'b1;
                  st_reg   <= ST_IDLE;
               end
            end
            ST_PULSE: begin
               cnt_reg <= cnt_reg + 32'h1;
               if (cnt_reg >= pulse_reg - 32'h1) begin
                  pins_reg.ce_n <= 1'b1;
                  pins_reg.we_n <= 1'b1;
                  busy_reg      <= 1'b0;
                  done_ev       <= 1'b1;
                  st_reg        <= ST_IDLE;
               end
            end
            default: st_reg <= ST_IDLE;
         endcase
      end
   end

   assign flash_o = pins_reg;
endmodule : fes_host

// file: inc/fes_pkg.sv
// Purpose: constants and types for the flash status sequencer host
// Assumes: aclk at 125 MHz, AXI4-Lite register port, byte-wide flash pins
// Notes:   holds register map, field positions and pin timing counts
package fes_pkg;
   localparam int unsigned CLK_MHZ          = 125;
   localparam int unsigned T_RESET_LOW_NS   = 500;
   localparam int unsigned T_RESET_HIGH_NS  = 50;
   localparam int unsigned T_READY_OP_US    = 20;
   localparam int unsigned T_ELEV_SETUP_US  = 4;
   localparam int unsigned T_PROT_PULSE_NS  = 100;
   localparam int unsigned T_ACCESS_NS      = 100;
   localparam int unsigned RST_LOW_CYC  = (T_RESET_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned RST_HIGH_CYC = (T_RESET_HIGH_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned READY_OP_CYC = T_READY_OP_US * CLK_MHZ;
   localparam int unsigned ELEV_CYC     = T_ELEV_SETUP_US * CLK_MHZ;
   localparam int unsigned PULSE_MIN_CYC = (T_PROT_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned ACCESS_CYC   = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_ADDR   = 8'h04;
   localparam logic [7:0] OFS_WDATA  = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_IRQ    = 8'h10;
   localparam logic [7:0] OFS_MASK   = 8'h14;
   localparam logic [7:0] OFS_TMO    = 8'h18;
   localparam logic [7:0] OFS_PULSE  = 8'h1c;
   localparam logic [7:0] OFS_RDATA  = 8'h20;

   // ctrl: [2:0] command, [3] use toggle method, write starts
   localparam int unsigned CTRL_CMD_LSB  = 0;
   localparam int unsigned CTRL_TOG_BIT  = 3;
   localparam int unsigned IRQ_DONE_BIT  = 0;
   localparam int unsigned IRQ_TMO_BIT   = 1;
   localparam logic [31:0] TMO_RESET     = 32'h0ee6_b280; // 2 s of cycles
   localparam logic [31:0] PULSE_RESET   = 32'h0000_04e2; // 10 us
   localparam int unsigned DATA_POLL_BIT = 7;
   localparam int unsigned TOGGLE_STATUS_BIT = 6;
   localparam int unsigned SECTOR_SELECT_LOW_BIT  = 12;
   localparam int unsigned SECTOR_SELECT_HIGH_BIT = 17;

   typedef enum logic [2:0] {
      FES_CMD_READ   = 3'b000,
      FES_CMD_WRITE  = 3'b001,
      FES_CMD_POLL   = 3'b010,
      FES_CMD_RESET  = 3'b011,
      FES_CMD_PROT   = 3'b100,
      FES_CMD_UNPROT = 3'b101,
      FES_CMD_TEMP   = 3'b110
   } fes_cmd_t;

   typedef struct packed {
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic        reset_n;
      logic        elevated_id_voltage;
      logic [18:0] addr;
      logic [7:0]  dq_out;
      logic        dq_oe_n;
   } fes_pins_t;
endpackage : fes_pkg

// file: tb/fes_host_sva.sv
// Purpose: pin duty and bus response checks on the flash status host
// Assumes: bound to fes_host, sees its ports only
// Notes:   run-length counters replace repeats longer than eight cycles
`timescale 1ns/1ps
module fes_host_sva
   import fes_pkg::*;
(
   input wire logic               aclk,     // clock
   input wire logic               aresetn,  // sync reset, low active
   input wire logic               s_bvalid, // write response valid
   input wire logic               s_bready, // write response ready
   input wire logic               s_rvalid, // read valid
   input wire logic               s_rready, // read ready
   input wire fes_pkg::fes_pins_t flash_o   // flash pin drive
);
   logic [15:0] rst_low_reg, we_low_reg, elev_reg;
   // run lengths of reset low, write strobe low, elevated level
   always_ff @(posedge aclk)
      rst_low_reg <= (!aresetn || flash_o.reset_n) ? 16'h0 : rst_low_reg + 16'h1;
   always_ff @(posedge aclk)
      we_low_reg <= (!aresetn || flash_o.we_n) ? 16'h0 : we_low_reg + 16'h1;
   always_ff @(posedge aclk)
      elev_reg <= (!aresetn || !flash_o.elevated_id_voltage) ? 16'h0 : elev_reg + 16'h1;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   reset_pulse_a: assert property (
      $rose(flash_o.reset_n) |-> rst_low_reg >= RST_LOW_CYC) else $error("reset pulse short");
   reset_recover_a: assert property (
      $rose(flash_o.reset_n) |-> flash_o.ce_n [*7]) else $error("access too soon after reset");
   write_pulse_a: assert property (
      $rose(flash_o.we_n) |-> we_low_reg >= PULSE_MIN_CYC) else $error("write pulse short");
   elev_setup_a: assert property (
      !flash_o.we_n && flash_o.elevated_id_voltage |-> elev_reg >= ELEV_CYC)
      else $error("write too soon after elevated reset");
   poll_addr_a: assert property (
      !flash_o.oe_n && $past(!flash_o.oe_n) |-> $stable(flash_o.addr))
      else $error("address moved during read");
   read_strobe_a: assert property (
      $fell(flash_o.oe_n) |-> flash_o.we_n && flash_o.dq_oe_n ##1 (!flash_o.oe_n) [*8])
      else $error("status read strobe broken");
   bresp_once_a: assert property (s_bvalid && s_bready |=> !s_bvalid)
      else $error("write response repeated");
   rdata_once_a: assert property (s_rvalid && s_rready |=> !s_rvalid)
      else $error("read response repeated");
endmodule : fes_host_sva

bind fes_host fes_host_sva u_fes_host_sva (.aclk(aclk), .aresetn(aresetn),
   .s_bvalid(s_bvalid), .s_bready(s_bready), .s_rvalid(s_rvalid),
   .s_rready(s_rready), .flash_o(flash_o));

// file: tb/fes_flash_model.sv
// Purpose: behavioural byte flash answering status reads
// Assumes: each write pulse taken while not busy starts one operation
// Notes:   busy lasts a number of status reads, not a time
`timescale 1ns/1ps
module fes_flash_model
   import fes_pkg::*;
(
   input wire fes_pkg::fes_pins_t pins,  // host pin drive
   input wire logic               stuck, // hold busy until a reset pulse
   output     logic [7:0]         dq     // data pins to host
);
   logic [7:0] mem [int];
   logic [7:0] op_data = 8'h00;
   logic       tog = 1'b0;
   int         busy = 0;
   initial dq = 8'h00;
   // 0x10 erases the array, 0x30 one sector, anything else programs
   always @(negedge pins.we_n) begin
      if (!pins.ce_n && pins.reset_n && busy == 0) begin
         op_data = pins.dq_out;
         busy = (op_data == 8'h10 || op_data == 8'h30) ? 5 : 3;
         if (op_data == 8'h10) begin
            mem.delete();
         end else if (op_data == 8'h30) begin
            for (int i = 0; i < 4096; i++) mem.delete({pins.addr[18:12], 12'h000} + i);
         end else begin
            mem[int'(pins.addr)] = op_data;
         end
      end
   end
   always @(negedge pins.oe_n) begin
      if (!pins.ce_n && pins.reset_n && busy != 0) begin
         tog = ~tog;
         dq = {(busy == 5 || op_data == 8'h30 || op_data == 8'h10) ? 1'b0 : ~op_data[7], tog, 6'h00};
         busy = stuck ? busy : busy - 1;
      end else if (!pins.ce_n) begin
         dq = mem.exists(int'(pins.addr)) ? mem[int'(pins.addr)] : 8'hff;
      end
   end
   // released bus shows the inverse, never a held value
   always @(posedge pins.oe_n) dq = ~dq;
   always @(negedge pins.reset_n) busy = 0;
endmodule : fes_flash_model

// file: tb/fes_host_test.sv
// Purpose: self-checking bench for the flash status host
// Assumes: flash model ends busy after a few status reads
// Notes:   timeout register cut to 1000 cycles for the hang case
`timescale 1ns/1ps
module fes_host_test;
   import fes_pkg::*;
   logic        aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
   logic        s_bready, s_arvalid, s_arready, s_rvalid, s_rready, irq, stuck;
   logic [7:0]  s_awaddr, s_araddr, flash_dq_i;
   logic [31:0] s_wdata, s_rdata, rd;
   logic [1:0]  s_bresp, s_rresp, rsp;
   logic [3:0]  s_wstrb = 4'hf;
   fes_pins_t   flash_o;
   int          n_mismatch = 0, total_checks = 0, cyc = 0;
   fes_host u_fes_host (
      .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
      .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
      .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
      .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
      .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .flash_o(flash_o),
      .flash_dq_i(flash_dq_i), .irq(irq));
   fes_flash_model u_fes_flash_model (.pins(flash_o), .stuck(stuck), .dq(flash_dq_i));
   always #4 aclk = ~aclk;
   task automatic final_report();
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   // handshakes judged on the rising edge itself; each valid held until taken
   task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      {s_awaddr, s_wdata, s_araddr} <= {a, d, a};
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} <= {wr, wr, wr, !wr, !wr};
      while (!done) begin
         @(posedge aclk);
         if (s_awvalid && s_awready) s_awvalid <= 1'b0;
         if (s_wvalid && s_wready) s_wvalid <= 1'b0;
         if (s_arvalid && s_arready) s_arvalid <= 1'b0;
         done = wr ? (s_bvalid && s_bready) : (s_rvalid && s_rready);
         if (done && wr) rsp = s_bresp;
         if (done && !wr) {rd, rsp} = {s_rdata, s_rresp};
      end
      {s_bready, s_rready} <= 2'b00;
   endtask : axi
   task automatic cmd(input fes_cmd_t c, input logic tog);
      axi(1'b1, OFS_CTRL, {28'h0, tog, c});
      for (int n = 0; n < 20000 && irq !== 1'b1; n++) @(negedge aclk);
      chk({31'h0, irq}, 32'h1);
      axi(1'b0, OFS_IRQ, 32'h0);
      axi(1'b1, OFS_IRQ, 32'h3);
   endtask : cmd
   task automatic op(input logic [18:0] a, input logic [7:0] d, input fes_cmd_t c, input logic t);
      axi(1'b1, OFS_ADDR, {13'h0, a});
      axi(1'b1, OFS_WDATA, {24'h0, d});
      cmd(c, t);
   endtask : op
   task automatic rdback(input logic [18:0] a, input logic [7:0] exp);
      op(a, 8'h00, FES_CMD_READ, 1'b0);
      axi(1'b0, OFS_RDATA, 32'h0);
      chk(rd, {24'h0, exp});
   endtask : rdback
   task automatic t_regs_irq();
      axi(1'b0, OFS_TMO, 32'h0);
      chk(rd, TMO_RESET);
      axi(1'b0, 8'h24, 32'h0);
      chk({rd[29:0], rsp}, 32'h2);
      axi(1'b1, 8'h24, 32'h0);
      chk({30'h0, rsp}, 32'h2);
      axi(1'b1, OFS_CTRL, {29'h0, FES_CMD_READ});
      repeat (64) @(negedge aclk);
      axi(1'b1, OFS_MASK, 32'h0);
      chk({31'h0, irq}, 32'h0);
      axi(1'b1, OFS_MASK, 32'h3);
      // irq is a flop behind the mask, so it settles one edge later
      @(negedge aclk);
      chk({31'h0, irq}, 32'h1);
      axi(1'b1, OFS_IRQ, 32'h3);
      axi(1'b0, OFS_IRQ, 32'h0);
      chk({rd[30:0], irq}, 32'h0);
   endtask : t_regs_irq
   task automatic t_prog_erase();
      op(19'h01234, 8'h5a, FES_CMD_WRITE, 1'b0);
      cmd(FES_CMD_POLL, 1'b0);
      rdback(19'h01234, 8'h5a);
      op(19'h01234, 8'h10, FES_CMD_WRITE, 1'b0);
      cmd(FES_CMD_POLL, 1'b1);
      rdback(19'h01234, 8'hff);
   endtask : t_prog_erase
   task automatic t_sector();
      op(19'h21000, 8'h00, FES_CMD_WRITE, 1'b0);
      cmd(FES_CMD_POLL, 1'b0);
      op(19'h22000, 8'h00, FES_CMD_WRITE, 1'b0);
      cmd(FES_CMD_POLL, 1'b0);
      op(19'h21abc, 8'h30, FES_CMD_WRITE, 1'b0);
      cmd(FES_CMD_POLL, 1'b1);
      rdback(19'h21000, 8'hff);
      rdback(19'h22000, 8'h00);
   endtask : t_sector
   task automatic t_abort_pins();
      axi(1'b1, OFS_TMO, 32'h0000_03e8);
      stuck = 1'b1;
      op(19'h03000, 8'h77, FES_CMD_WRITE, 1'b0);
      cmd(FES_CMD_POLL, 1'b1);
      chk(rd & 32'h2, 32'h2);
      stuck = 1'b0;
      cmd(FES_CMD_RESET, 1'b0);
      rdback(19'h22000, 8'h00);
      cmd(FES_CMD_PROT, 1'b0);
      axi(1'b1, OFS_PULSE, 32'h0000_0001);
      axi(1'b0, OFS_PULSE, 32'h0000_0000);
      chk(rd, PULSE_MIN_CYC);
      cmd(FES_CMD_UNPROT, 1'b0);
      cmd(FES_CMD_TEMP, 1'b0);
      axi(1'b0, OFS_STATUS, 32'h0);
      chk(rd & 32'h4, 32'h4);
      op(19'h01000, 8'h00, FES_CMD_WRITE, 1'b0);
      cmd(FES_CMD_TEMP, 1'b0);
   endtask : t_abort_pins
   // hang guard, well above the roughly 8500 cycles the run needs
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         final_report();
      end
   end
   initial begin
      {aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, stuck} = '0;
      {s_awaddr, s_araddr, s_wdata} = '0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs_irq();
      t_prog_erase();
      t_sector();
      t_abort_pins();
      final_report();
   end
endmodule : fes_host_test
